//--- core/tcd_decode.sv
// Serial programming port and control decoder of the radio transceiver.
// Assumes pins ser_clk, ser_data, ser_en and crystal_input are asynchronous
// and at most a quarter of the core clock rate; rx_data_raw is core-clocked.
`timescale 1ns/1ps
`default_nettype none
module tcd_decode #(
   parameter int SYNC_W = 4
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst_n,
   // Serial programming pins
   input  wire logic ser_clk,
   input  wire logic ser_data,
   input  wire logic ser_en,
   // Crystal reference pin and recovered data
   input  wire logic crystal_input,
   input  wire logic rx_data_raw,
   // Receive path controls
   output logic      image_side_select,
   output logic      second_if_filter_select,
   output logic      earpiece_on,
   output logic      data_out,
   // Clock and power controls
   output logic      host_clock_swing_select,
   output logic      crystal_osc_on,
   output logic      crystal_drive_normal,
   output logic      regulator_on,
   output logic      regulator_tied,
   output logic      doubler_on,
   output logic      doubler_clk,
   output logic      host_clock_pin,
   // Operating mode
   output logic      mode_inactive,
   output logic      mode_rx_only,
   output logic      mode_active,
   output tcd_pkg::tcd_div_type div_active
);
   import tcd_pkg::*;

   if (SYNC_W != 4) begin : g_chk
      $error("tcd_decode serves exactly four synchronised pins");
   end

   logic [SYNC_W-1:0] pin_raw;
   logic [SYNC_W-1:0] sync_a;
   logic [SYNC_W-1:0] sync_b;
   logic [SYNC_W-1:0] sync_c;
   assign pin_raw = {crystal_input, ser_en, ser_data, ser_clk};

   genvar gi;
   generate
      for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               // Idle levels, so no false enable edge follows reset
               sync_a[gi] <= PIN_IDLE[gi];
               sync_b[gi] <= PIN_IDLE[gi];
               sync_c[gi] <= PIN_IDLE[gi];
            end else begin
               sync_a[gi] <= pin_raw[gi];
               sync_b[gi] <= sync_a[gi];
               sync_c[gi] <= sync_b[gi];
            end
         end
      end
   endgenerate

   logic sclk_fall;
   logic en_rise;
   logic en_level;
   logic sdata_s;
   logic xtal_edge;
   assign sclk_fall = sync_c[0] & ~sync_b[0];
   assign sdata_s   = sync_b[1];
   assign en_level  = sync_b[2];
   assign en_rise   = sync_b[2] & ~sync_c[2];
   assign xtal_edge = sync_b[3] ^ sync_c[3];

   // Serial shift register and frame counter
   logic [FRAME_BITS-1:0] shift_reg;
   logic [4:0]            bit_cnt_reg;
   logic [2:0]            hold_cnt_reg;
   logic                  take_bit;
   logic                  frame_load;
   logic                  div_commit;
   logic [DATA_W-1:0]     frame_data;
   logic [ADDR_W-1:0]     frame_addr;
   assign take_bit   = sclk_fall && !en_level && (hold_cnt_reg == 3'h0);
   assign frame_load = en_rise && (bit_cnt_reg == 5'(FRAME_BITS));
   assign div_commit = en_rise && (bit_cnt_reg == 5'h00);
   assign frame_data = shift_reg[FRAME_BITS-1 -: DATA_W];
   assign frame_addr = shift_reg[ADDR_W-1:0];

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_reg   <= '0;
         bit_cnt_reg <= 5'h00;
      end else if (en_rise) begin
         bit_cnt_reg <= 5'h00;
      end else if (take_bit) begin
         shift_reg <= {shift_reg[FRAME_BITS-2:0], sdata_s};
         if (bit_cnt_reg != 5'h1f) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
         end
      end
   end

   // Serial clock falls are ignored during the hold after a commit edge
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_cnt_reg <= 3'h0;
      end else if (div_commit) begin
         hold_cnt_reg <= 3'(HOLD_CYC);
      end else if (hold_cnt_reg != 3'h0) begin
         hold_cnt_reg <= hold_cnt_reg - 3'h1;
      end
   end

   // Control words, loaded only from a complete frame
   logic [DATA_W-1:0] rx_ctrl_reg;
   logic [DATA_W-1:0] tx_ctrl_reg;
   logic [DATA_W-1:0] pwr_ctrl_reg;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_ctrl_reg  <= RST_RX_CTRL;
         tx_ctrl_reg  <= RST_TX_CTRL;
         pwr_ctrl_reg <= RST_PWR_CTRL;
      end else if (frame_load) begin
         unique case (frame_addr)
            ADDR_RX_CTRL:  rx_ctrl_reg  <= frame_data;
            ADDR_TX_CTRL:  tx_ctrl_reg  <= frame_data;
            ADDR_PWR_CTRL: pwr_ctrl_reg <= frame_data;
            default:       ;
         endcase
      end
   end

   // Decoded controls
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         // Power-on values, so nothing moves at release without a load
         image_side_select       <= RST_RX_CTRL[POS_SIDE];
         second_if_filter_select <= RST_RX_CTRL[POS_FILTER];
         earpiece_on             <= RST_RX_CTRL[POS_EAR];
         host_clock_swing_select <= RST_TX_CTRL[POS_SWING];
         crystal_osc_on          <= RST_TX_CTRL[POS_XRUN];
         crystal_drive_normal    <= RST_PWR_CTRL[POS_XDRIVE];
         regulator_on            <= RST_PWR_CTRL[POS_REG];
         regulator_tied          <= ~RST_PWR_CTRL[POS_REG];
         doubler_on              <= RST_TX_CTRL[POS_DOUBLER];
      end else begin
         image_side_select       <= rx_ctrl_reg[POS_SIDE];
         second_if_filter_select <= rx_ctrl_reg[POS_FILTER];
         earpiece_on             <= rx_ctrl_reg[POS_EAR];
         host_clock_swing_select <= tx_ctrl_reg[POS_SWING];
         crystal_osc_on          <= tx_ctrl_reg[POS_XRUN];
         crystal_drive_normal    <= pwr_ctrl_reg[POS_XDRIVE];
         regulator_on            <= pwr_ctrl_reg[POS_REG];
         regulator_tied          <= ~pwr_ctrl_reg[POS_REG];
         doubler_on              <= tx_ctrl_reg[POS_DOUBLER];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_inactive <= 1'b1;
         mode_rx_only  <= 1'b0;
         mode_active   <= 1'b0;
      end else begin
         mode_inactive <= ~pwr_ctrl_reg[POS_MODE_HI];
         mode_rx_only  <= pwr_ctrl_reg[POS_MODE_HI] & ~pwr_ctrl_reg[POS_MODE_LO];
         mode_active   <= pwr_ctrl_reg[POS_MODE_HI] & pwr_ctrl_reg[POS_MODE_LO];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         data_out <= 1'b0;
      end else begin
         data_out <= rx_data_raw ^ rx_ctrl_reg[POS_POL];
      end
   end

   // Divider ratio takes effect only on an extra enable rise
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         div_active <= tcd_div_type'(RST_PWR_CTRL[POS_DIV_LO +: DIV_W]);
      end else if (div_commit) begin
         div_active <= tcd_div_type'(pwr_ctrl_reg[POS_DIV_LO +: DIV_W]);
      end
   end

   // Host clock: counts crystal half periods while the oscillator runs
   logic       xtal_tick;
   logic       div_on;
   logic       alt_reg;
   logic [7:0] half_cnt_reg;
   logic [7:0] half_target;
   assign xtal_tick = xtal_edge && crystal_osc_on;

   always_comb begin
      div_on      = 1'b1;
      half_target = HALF_2;
      unique case (div_active)
         TCD_DIV_1:   half_target = HALF_1;
         TCD_DIV_2:   half_target = HALF_2;
         TCD_DIV_2P5: half_target = alt_reg ? HALF_3 : HALF_2;
         TCD_DIV_4:   half_target = HALF_4;
         TCD_DIV_128: half_target = HALF_128;
         TCD_DIV_OFF, TCD_DIV_X6, TCD_DIV_X7: div_on = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         host_clock_pin <= 1'b0;
         half_cnt_reg   <= 8'h00;
         alt_reg        <= 1'b0;
      end else if (!div_on) begin
         host_clock_pin <= 1'b0;
         half_cnt_reg   <= 8'h00;
         alt_reg        <= 1'b0;
      end else if (xtal_tick) begin
         if (half_cnt_reg + 8'h01 >= half_target) begin
            host_clock_pin <= ~host_clock_pin;
            half_cnt_reg   <= 8'h00;
            alt_reg        <= ~alt_reg;
         end else begin
            half_cnt_reg <= half_cnt_reg + 8'h01;
         end
      end
   end

   // Doubler clock: crystal over two, or the host clock when inactive
   logic xtal_half_reg;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         xtal_half_reg <= 1'b0;
      end else if (xtal_tick && sync_b[3]) begin
         xtal_half_reg <= ~xtal_half_reg;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         doubler_clk <= 1'b0;
      end else if (!doubler_on) begin
         doubler_clk <= 1'b0;
      end else begin
         doubler_clk <= mode_inactive ? host_clock_pin : xtal_half_reg;
      end
   end

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence s_load_rx;
      frame_load && (frame_addr == ADDR_RX_CTRL);
   endsequence
   sequence s_load_pwr;
      frame_load && (frame_addr == ADDR_PWR_CTRL);
   endsequence

   property p_side_load;
      logic b;
      (s_load_rx, b = frame_data[POS_SIDE]) |=> ##1 (image_side_select == b);
   endproperty
   a_side_load: assert property (p_side_load) else $error("sideband not loaded");

   property p_filter_load;
      logic b;
      (s_load_rx, b = frame_data[POS_FILTER]) |=> ##1 (second_if_filter_select == b);
   endproperty
   a_filter_load: assert property (p_filter_load) else $error("filter not loaded");

   property p_stable_no_load;
      !frame_load [*2] |=> $stable(image_side_select) && $stable(regulator_on)
                         && $stable(mode_inactive);
   endproperty
   a_stable_no_load: assert property (p_stable_no_load) else $error("output moved");

   property p_mode_decode;
      logic [1:0] m;
      (s_load_pwr, m = frame_data[POS_MODE_HI:POS_MODE_LO]) |=> ##1
         (mode_inactive == !m[1]) && (mode_rx_only == (m == 2'h2))
         && (mode_active == (m == 2'h3));
   endproperty
   a_mode_decode: assert property (p_mode_decode) else $error("mode decode wrong");

   property p_reg_tie;
      regulator_on != regulator_tied;
   endproperty
   a_reg_tie: assert property (p_reg_tie) else $error("regulator tie wrong");

   property p_div_commit;
      $changed(div_active) |-> $past(div_commit);
   endproperty
   a_div_commit: assert property (p_div_commit) else $error("divider changed alone");

   property p_hold_ignore;
      div_commit |=> (hold_cnt_reg != 3'h0 && !take_bit) [*5] ##1 (hold_cnt_reg == 3'h0);
   endproperty
   a_hold_ignore: assert property (p_hold_ignore) else $error("hold not kept");

   property p_div_off;
      !div_on |=> !host_clock_pin;
   endproperty
   a_div_off: assert property (p_div_off) else $error("host clock not static");

   property p_pol;
      $past(rx_ctrl_reg[POS_POL]) |-> (data_out != $past(rx_data_raw));
   endproperty
   a_pol: assert property (p_pol) else $error("data not inverted");

   property p_dbl_off;
      !doubler_on |=> !doubler_clk;
   endproperty
   a_dbl_off: assert property (p_dbl_off) else $error("doubler clock running");

   property p_div1_toggle;
      (div_active == TCD_DIV_1) && xtal_tick && $stable(div_active)
         |=> $changed(host_clock_pin);
   endproperty
   a_div1_toggle: assert property (p_div1_toggle) else $error("divide by one wrong");

   property p_inactive_dbl;
      doubler_on && mode_inactive && $stable(doubler_on) && $stable(mode_inactive)
         |=> (doubler_clk == $past(host_clock_pin));
   endproperty
   a_inactive_dbl: assert property (p_inactive_dbl) else $error("doubler source wrong");

endmodule : tcd_decode
`default_nettype wire

//--- core/tcd_pkg.sv
// Constants for the transceiver control decoder: frame layout, field
// positions, power-on values, divider codes and timing counts.
// Assumes a single 100 MHz core clock; all pins are sampled into it.
package tcd_pkg;
   localparam int FRAME_BITS = 19;
   localparam int DATA_W     = 16;
   localparam int ADDR_W     = 3;
   localparam logic [ADDR_W-1:0] ADDR_RX_CTRL  = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_TX_CTRL  = 3'h4;
   localparam logic [ADDR_W-1:0] ADDR_PWR_CTRL = 3'h5;
   localparam logic [DATA_W-1:0] RST_RX_CTRL  = 16'h07cf;
   localparam logic [DATA_W-1:0] RST_TX_CTRL  = 16'h07cc;
   localparam logic [DATA_W-1:0] RST_PWR_CTRL = 16'h3008;
   // Idle pin levels {crystal, enable, data, clock}: enable rests high
   localparam logic [3:0] PIN_IDLE = 4'h4;
   // Field positions in the rx, tx and power words
   localparam int POS_SIDE    = 15;
   localparam int POS_EAR     = 12;
   localparam int POS_FILTER  = 6;
   localparam int POS_POL     = 5;
   localparam int POS_SWING   = 14;
   localparam int POS_DOUBLER = 12;
   localparam int POS_XRUN    = 3;
   localparam int POS_REG     = 15;
   localparam int POS_MODE_HI = 14;
   localparam int POS_MODE_LO = 13;
   localparam int POS_XDRIVE  = 12;
   localparam int POS_DIV_LO  = 0;
   localparam int DIV_W       = 3;
   typedef enum logic [DIV_W-1:0] {
      TCD_DIV_OFF = 3'h0, TCD_DIV_2  = 3'h1, TCD_DIV_2P5 = 3'h2, TCD_DIV_4 = 3'h3,
      TCD_DIV_1   = 3'h4, TCD_DIV_128 = 3'h5, TCD_DIV_X6 = 3'h6, TCD_DIV_X7 = 3'h7
   } tcd_div_type;
   // Host clock toggles after this many crystal half periods
   localparam logic [7:0] HALF_1   = 8'h01;
   localparam logic [7:0] HALF_2   = 8'h02;
   localparam logic [7:0] HALF_3   = 8'h03;
   localparam logic [7:0] HALF_4   = 8'h04;
   localparam logic [7:0] HALF_128 = 8'h80;
   localparam int CLK_PERIOD_NS = 10;
   localparam int HOLD_NS       = 50;
   localparam int HOLD_CYC      = (HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : tcd_pkg

//--- test/tcd_host_model.sv
// Host microcontroller model driving the 3-wire programming pins.
// Assumes the bench calls its tasks; pins move only at core_clk falls.
`timescale 1ns/1ps
`default_nettype none
module tcd_host_model (
   // Clock
   input  wire logic core_clk,
   // Serial pins
   output var logic  ser_clk,
   output var logic  ser_data,
   output var logic  ser_en
);
   import tcd_pkg::*;
   initial begin
      ser_clk  = 1'b0;
      ser_data = 1'b0;
      ser_en   = 1'b1;
   end
   // Sends the first n bits of f, MSB first; clock rests low between frames
   task automatic send(input logic [FRAME_BITS-1:0] f, input int n);
      @(negedge core_clk);
      ser_en <= 1'b0;
      repeat (4) @(negedge core_clk);
      for (int i = 0; i < n; i++) begin
         ser_data <= f[FRAME_BITS-1-i];
         ser_clk  <= 1'b1;
         repeat (4) @(negedge core_clk);
         ser_clk <= 1'b0;
         repeat (4) @(negedge core_clk);
      end
      // Released data line shows the inverse of the last bit
      ser_data <= ~ser_data;
      ser_en   <= 1'b1;
      repeat (8) @(negedge core_clk);
   endtask : send
   // Extra enable rise with no bits, then a quiet hold
   task automatic commit();
      @(negedge core_clk);
      ser_en <= 1'b0;
      repeat (4) @(negedge core_clk);
      ser_en <= 1'b1;
      repeat (HOLD_CYC + 4) @(negedge core_clk);
   endtask : commit
endmodule : tcd_host_model
`default_nettype wire

//--- test/tcd_testbench.sv
// Self-checking bench for the transceiver control decoder.
// Assumes tcd_host_model drives the serial pins; the crystal is made here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import tcd_pkg::*;
   logic        core_clk      = 1'b0;
   logic        rst_n         = 1'b0;
   logic        crystal_input = 1'b0;
   logic        rx_data_raw   = 1'b0;
   wire logic   ser_clk, ser_data, ser_en;
   logic        image_side_select, second_if_filter_select, earpiece_on, data_out;
   logic        host_clock_swing_select, crystal_osc_on, crystal_drive_normal;
   logic        regulator_on, regulator_tied, doubler_on, doubler_clk, host_clock_pin;
   logic        mode_inactive, mode_rx_only, mode_active;
   tcd_div_type div_active;
   int          fails = 0;
   int          n_compared = 0;
   int          cyc = 0;

   tcd_host_model i_host (.core_clk, .ser_clk, .ser_data, .ser_en);
   tcd_decode i_dut (.core_clk, .rst_n, .ser_clk, .ser_data, .ser_en, .crystal_input,
      .rx_data_raw, .image_side_select, .second_if_filter_select, .earpiece_on, .data_out,
      .host_clock_swing_select, .crystal_osc_on, .crystal_drive_normal, .regulator_on,
      .regulator_tied, .doubler_on, .doubler_clk, .host_clock_pin, .mode_inactive,
      .mode_rx_only, .mode_active, .div_active);

   always #5 core_clk = ~core_clk;
   // Crystal half period of 4 core cycles
   always begin
      repeat (4) @(negedge core_clk);
      crystal_input <= ~crystal_input;
   end

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : summarize

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 60000) begin
         fails++;
         summarize();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic t_reset();
      chk({image_side_select, second_if_filter_select, earpiece_on, host_clock_swing_select,
           crystal_osc_on, crystal_drive_normal, regulator_on, regulator_tied, doubler_on,
           mode_inactive, mode_rx_only, mode_active}, 16'h04d4, "power-on");
      chk(div_active, TCD_DIV_OFF, "power-on divider");
      $display("done: reset");
   endtask : t_reset

   task automatic t_rx();
      logic [15:0] w;
      for (int v = 0; v < 2; v++) begin
         w = '0;
         w[POS_SIDE] = v[0];
         w[POS_EAR] = v[0];
         w[POS_FILTER] = !v[0];
         w[POS_POL] = v[0];
         i_host.send({w, ADDR_RX_CTRL}, FRAME_BITS);
         chk({image_side_select, earpiece_on, second_if_filter_select},
             {v[0], v[0], !v[0]}, "rx fields");
         for (int d = 0; d < 2; d++) begin
            rx_data_raw <= d[0];
            repeat (3) @(negedge core_clk);
            chk(data_out, d[0] ^ v[0], "data polarity");
         end
      end
      $display("done: rx");
   endtask : t_rx

   task automatic t_tx();
      logic [15:0] w;
      for (int v = 0; v < 2; v++) begin
         w = '0;
         w[POS_SWING] = v[0];
         w[POS_DOUBLER] = v[0];
         w[POS_XRUN] = v[0];
         i_host.send({w, ADDR_TX_CTRL}, FRAME_BITS);
         chk({host_clock_swing_select, doubler_on, crystal_osc_on}, {3{v[0]}},
             "tx fields");
         repeat (64) @(negedge core_clk);
         chk(host_clock_pin, 1'b0, "host clock off");
      end
      $display("done: tx");
   endtask : t_tx

   task automatic t_refuse();
      i_host.send({16'h0000, 3'h1}, FRAME_BITS);
      i_host.send({16'h0000, ADDR_TX_CTRL}, FRAME_BITS - 1);
      chk({host_clock_swing_select, doubler_on, crystal_osc_on}, 16'h0007,
          "dropped frames");
      $display("done: refuse");
   endtask : t_refuse

   task automatic t_mode();
      logic [15:0] w;
      logic [2:0]  e;
      for (int m = 0; m < 4; m++) begin
         w = '0;
         w[POS_REG] = m[0];
         w[POS_MODE_HI] = m[1];
         w[POS_MODE_LO] = m[0];
         w[POS_XDRIVE] = m[1];
         e = m[1] ? (m[0] ? 3'h1 : 3'h2) : 3'h4;
         i_host.send({w, ADDR_PWR_CTRL}, FRAME_BITS);
         chk({regulator_on, regulator_tied, crystal_drive_normal}, {m[0], !m[0], m[1]},
             "power fields");
         chk({mode_inactive, mode_rx_only, mode_active}, e, "mode");
      end
      $display("done: mode");
   endtask : t_mode

   task automatic measure(output int th, output int td);
      logic ph;
      logic pd;
      th = 0;
      td = 0;
      ph = host_clock_pin;
      pd = doubler_clk;
      repeat (2048) begin
         @(negedge core_clk);
         if (host_clock_pin !== ph) th++;
         if (doubler_clk !== pd) td++;
         ph = host_clock_pin;
         pd = doubler_clk;
      end
   endtask : measure

   // Toggles in 2048 cycles: 512 crystal half periods over the ratio
   task automatic t_div();
      int          ex[8] = '{0, 256, 204, 128, 512, 4, 0, 0};
      int          th;
      int          td;
      logic [15:0] w;
      for (int c = 0; c < 9; c++) begin
         w = '0;
         w[POS_REG] = 1'b1;
         w[POS_MODE_HI] = (c == 8);
         w[POS_MODE_LO] = (c == 8);
         w[POS_DIV_LO +: DIV_W] = (c == 8) ? 3'h5 : c[2:0];
         i_host.send({w, ADDR_PWR_CTRL}, FRAME_BITS);
         chk(div_active, (c == 0) ? 3'h0 : 3'(c - 1), "divider before commit");
         i_host.commit();
         repeat (8) @(negedge core_clk);
         chk(div_active, w[POS_DIV_LO +: DIV_W], "divider committed");
         measure(th, td);
         if (c == 8) begin
            chk(td >= 255 && td <= 257, 1'b1, "doubler crystal/2");
         end else begin
            chk(ex[c] == 0 ? th == 0 : (th >= ex[c] - 1 && th <= ex[c] + 1), 1'b1,
                "host clock rate");
            chk(td >= th - 1 && td <= th + 1, 1'b1, "doubler follows host");
            if (ex[c] == 0) chk(host_clock_pin, 1'b0, "host clock static");
         end
      end
      $display("done: divider");
   endtask : t_div

   initial begin
      repeat (4) @(negedge core_clk);
      rst_n <= 1'b1;
      repeat (4) @(negedge core_clk);
      t_reset();
      t_rx();
      t_tx();
      t_refuse();
      t_mode();
      t_div();
      summarize();
   end
endmodule : testbench
`default_nettype wire
